/* rtc_time_pkg.sv */
// How it works
// - Mask bits 5-7 skip year-day, month, year.
// - Packed views are read-only; write counters instead.
// - Packed view fields start at byte boundaries.
// - View one: seconds, minutes, hours, weekday.
// - View two: day, month, year.
// - View three: day of year only.
// - Seconds count 0 to 59 per tick.
// - Minutes advance on seconds rollover, 0 to 59.
// - Hours advance on minutes rollover, 0 to 23.
// - Day of month follows month length, from 1.
// - Weekday advances on hours rollover, 0 to 6.
// - Day of year runs 1 to 365/366.
// - Month advances on day rollover, 1 to 12.
// - Year advances on month or year-day rollover.
// - Every counter has its own read/write address.
// - Leap year when year's two low bits zero.
// - Alarm fires on mismatch-to-match edge only.
// - Mask bits 0-4 skip second to weekday.
// - Counters run only while run enable is set.
package rtc_time_pkg;

    localparam logic [31:0] ADDR_RUN_CONTROL = 32'he002_4008;
    localparam logic [31:0] ADDR_ALARM_MASK = 32'he002_4010;
    localparam logic [31:0] ADDR_PACKED_TIME_LOW = 32'he002_4014;
    localparam logic [31:0] ADDR_PACKED_DATE = 32'he002_4018;
    localparam logic [31:0] ADDR_PACKED_DAY_OF_YEAR = 32'he002_401c;
    localparam logic [31:0] ADDR_SECONDS = 32'he002_4020;
    localparam logic [31:0] ADDR_MINUTES = 32'he002_4024;
    localparam logic [31:0] ADDR_HOURS = 32'he002_4028;
    localparam logic [31:0] ADDR_DAY_OF_MONTH = 32'he002_402c;
    localparam logic [31:0] ADDR_WEEKDAY = 32'he002_4030;
    localparam logic [31:0] ADDR_DAY_OF_YEAR = 32'he002_4034;
    localparam logic [31:0] ADDR_MONTH = 32'he002_4038;
    localparam logic [31:0] ADDR_YEAR = 32'he002_403c;

    localparam int RUN_ENABLE_BIT = 0;

    localparam int MASK_SECONDS_COMPARE = 0;
    localparam int MASK_MINUTES_COMPARE = 1;
    localparam int MASK_HOURS_COMPARE = 2;
    localparam int MASK_DAY_OF_MONTH_COMPARE = 3;
    localparam int MASK_WEEKDAY_COMPARE = 4;
    localparam int MASK_DAY_OF_YEAR_COMPARE = 5;
    localparam int MASK_MONTH_COMPARE = 6;
    localparam int MASK_YEAR_COMPARE = 7;

    localparam int TIME_SEC_LSB = 0;
    localparam int TIME_MIN_LSB = 8;
    localparam int TIME_HOUR_LSB = 16;
    localparam int TIME_DOW_LSB = 24;
    localparam int DATE_DOM_LSB = 0;
    localparam int DATE_MONTH_LSB = 8;
    localparam int DATE_YEAR_LSB = 16;
    localparam int DOY_VIEW_LSB = 0;

    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [5:0] MIN_LAST = 6'h3b;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [2:0] DOW_LAST = 3'h6;
    localparam logic [8:0] DOY_LAST_NORMAL = 9'h16d;
    localparam logic [8:0] DOY_LAST_LEAP = 9'h16e;
    localparam logic [3:0] MONTH_LAST = 4'hc;
    localparam logic [4:0] DOM_FIRST = 5'h01;
    localparam logic [8:0] DOY_FIRST = 9'h001;
    localparam logic [3:0] MONTH_FIRST = 4'h1;

    localparam logic [3:0] MONTH_FEB = 4'h2;
    localparam logic [3:0] MONTH_APR = 4'h4;
    localparam logic [3:0] MONTH_JUN = 4'h6;
    localparam logic [3:0] MONTH_SEP = 4'h9;
    localparam logic [3:0] MONTH_NOV = 4'hb;
    localparam logic [4:0] DAYS_FEB_NORMAL = 5'h1c;
    localparam logic [4:0] DAYS_FEB_LEAP = 5'h1d;
    localparam logic [4:0] DAYS_SHORT = 5'h1e;
    localparam logic [4:0] DAYS_LONG = 5'h1f;

    localparam logic [5:0] RST_SECONDS = 6'h00;
    localparam logic [5:0] RST_MINUTES = 6'h00;
    localparam logic [4:0] RST_HOURS = 5'h00;
    localparam logic [4:0] RST_DAY_OF_MONTH = 5'h01;
    localparam logic [2:0] RST_WEEKDAY = 3'h0;
    localparam logic [8:0] RST_DAY_OF_YEAR = 9'h001;
    localparam logic [3:0] RST_MONTH = 4'h1;
    localparam logic [11:0] RST_YEAR = 12'h000;
    localparam logic [7:0] RST_ALARM_MASK = 8'hff;
    localparam logic RST_RUN_ENABLE = 1'b0;

endpackage

/* rtc_month_days.sv */
`timescale 1ns/1ps
module rtc_month_days (
    input wire logic [3:0] month,
    input wire logic leap_year,
    output logic [4:0] last_day
);

    // Out-of-range month codes take the long length so a bad preset still wraps.
    always_comb begin
        unique case (month)
            rtc_time_pkg::MONTH_FEB: begin
                last_day = leap_year ? rtc_time_pkg::DAYS_FEB_LEAP : rtc_time_pkg::DAYS_FEB_NORMAL;
            end
            rtc_time_pkg::MONTH_APR, rtc_time_pkg::MONTH_JUN, rtc_time_pkg::MONTH_SEP, rtc_time_pkg::MONTH_NOV: begin
                last_day = rtc_time_pkg::DAYS_SHORT;
            end
            default: begin
                last_day = rtc_time_pkg::DAYS_LONG;
            end
        endcase
    end

endmodule

/* rtc_time_counter_chain.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module rtc_time_counter_chain (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic one_second_tick,
    input wire logic [5:0] alarm_seconds,
    input wire logic [5:0] alarm_minutes,
    input wire logic [4:0] alarm_hours,
    input wire logic [4:0] alarm_day_of_month,
    input wire logic [2:0] alarm_weekday,
    input wire logic [8:0] alarm_day_of_year,
    input wire logic [3:0] alarm_month,
    input wire logic [11:0] alarm_year,
    output logic alarm_event
);

    typedef struct packed {
        logic [5:0] seconds_count;
        logic [5:0] minutes_count;
        logic [4:0] hours_count;
        logic [4:0] day_of_month_count;
        logic [2:0] weekday_count;
        logic [8:0] day_of_year_count;
        logic [3:0] month_count;
        logic [11:0] year_count;
        logic [7:0] alarm_compare_mask;
        logic counter_run_enable;
        logic [31:0] read_data;
        logic match_prev;
        logic alarm_pulse;
    } chain_state_s;

    chain_state_s state_reg;
    chain_state_s state_next;

    logic access;
    logic setup;
    logic wr;
    logic addr_mapped;
    logic addr_view;
    logic [31:0] read_mux;
    logic [31:0] packed_time_low;
    logic [31:0] packed_date;
    logic [31:0] packed_day_of_year;
    logic leap_year;
    logic [4:0] dom_last;
    logic [8:0] doy_last;
    logic tick_run;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic dom_wrap;
    logic doy_wrap;
    logic month_wrap;
    logic year_step;
    logic [7:0] field_equal;
    logic match_now;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_dom;
    logic wr_dow;
    logic wr_doy;
    logic wr_month;
    logic wr_year;
    logic wr_any_counter;

    assign access = psel & penable;
    assign setup = psel & ~penable;
    assign wr = access & pwrite;

    assign wr_sec = wr & (paddr == rtc_time_pkg::ADDR_SECONDS);
    assign wr_min = wr & (paddr == rtc_time_pkg::ADDR_MINUTES);
    assign wr_hour = wr & (paddr == rtc_time_pkg::ADDR_HOURS);
    assign wr_dom = wr & (paddr == rtc_time_pkg::ADDR_DAY_OF_MONTH);
    assign wr_dow = wr & (paddr == rtc_time_pkg::ADDR_WEEKDAY);
    assign wr_doy = wr & (paddr == rtc_time_pkg::ADDR_DAY_OF_YEAR);
    assign wr_month = wr & (paddr == rtc_time_pkg::ADDR_MONTH);
    assign wr_year = wr & (paddr == rtc_time_pkg::ADDR_YEAR);
    assign wr_any_counter = wr_sec | wr_min | wr_hour | wr_dom | wr_dow | wr_doy | wr_month | wr_year;

    assign addr_view = (paddr == rtc_time_pkg::ADDR_PACKED_TIME_LOW) |
                       (paddr == rtc_time_pkg::ADDR_PACKED_DATE) |
                       (paddr == rtc_time_pkg::ADDR_PACKED_DAY_OF_YEAR);
    assign addr_mapped = addr_view |
                         (paddr == rtc_time_pkg::ADDR_RUN_CONTROL) |
                         (paddr == rtc_time_pkg::ADDR_ALARM_MASK) |
                         (paddr == rtc_time_pkg::ADDR_SECONDS) |
                         (paddr == rtc_time_pkg::ADDR_MINUTES) |
                         (paddr == rtc_time_pkg::ADDR_HOURS) |
                         (paddr == rtc_time_pkg::ADDR_DAY_OF_MONTH) |
                         (paddr == rtc_time_pkg::ADDR_WEEKDAY) |
                         (paddr == rtc_time_pkg::ADDR_DAY_OF_YEAR) |
                         (paddr == rtc_time_pkg::ADDR_MONTH) |
                         (paddr == rtc_time_pkg::ADDR_YEAR);

    // Zero wait states; the error answer flags unmapped addresses and writes to the read-only views.
    assign pready = 1'b1;
    assign pslverr = access & (~addr_mapped | (pwrite & addr_view));
    assign prdata = state_reg.read_data;
    assign alarm_event = state_reg.alarm_pulse;

    assign leap_year = (state_reg.year_count[1:0] == 2'b00);
    assign doy_last = leap_year ? rtc_time_pkg::DOY_LAST_LEAP : rtc_time_pkg::DOY_LAST_NORMAL;

    rtc_month_days u_month_days (
        .month(state_reg.month_count),
        .leap_year(leap_year),
        .last_day(dom_last)
    );

    // Wrap tests use >= so that a counter preset beyond its range still returns to its first value.
    assign tick_run = one_second_tick & state_reg.counter_run_enable;
    assign sec_wrap = tick_run & (state_reg.seconds_count >= rtc_time_pkg::SEC_LAST);
    assign min_wrap = sec_wrap & (state_reg.minutes_count >= rtc_time_pkg::MIN_LAST);
    assign hour_wrap = min_wrap & (state_reg.hours_count >= rtc_time_pkg::HOUR_LAST);
    assign dom_wrap = hour_wrap & (state_reg.day_of_month_count >= dom_last);
    assign doy_wrap = hour_wrap & (state_reg.day_of_year_count >= doy_last);
    assign month_wrap = dom_wrap & (state_reg.month_count >= rtc_time_pkg::MONTH_LAST);
    assign year_step = month_wrap | doy_wrap;

    always_comb begin
        packed_time_low = '0;
        packed_time_low[rtc_time_pkg::TIME_SEC_LSB +: 6] = state_reg.seconds_count;
        packed_time_low[rtc_time_pkg::TIME_MIN_LSB +: 6] = state_reg.minutes_count;
        packed_time_low[rtc_time_pkg::TIME_HOUR_LSB +: 5] = state_reg.hours_count;
        packed_time_low[rtc_time_pkg::TIME_DOW_LSB +: 3] = state_reg.weekday_count;
        packed_date = '0;
        packed_date[rtc_time_pkg::DATE_DOM_LSB +: 5] = state_reg.day_of_month_count;
        packed_date[rtc_time_pkg::DATE_MONTH_LSB +: 4] = state_reg.month_count;
        packed_date[rtc_time_pkg::DATE_YEAR_LSB +: 12] = state_reg.year_count;
        // The day-of-year counter is nine bits wide; the upper 23 bits of the view read zero.
        packed_day_of_year = '0;
        packed_day_of_year[rtc_time_pkg::DOY_VIEW_LSB +: 9] = state_reg.day_of_year_count;
    end

    always_comb begin
        read_mux = '0;
        unique case (paddr)
            rtc_time_pkg::ADDR_RUN_CONTROL: read_mux[rtc_time_pkg::RUN_ENABLE_BIT] = state_reg.counter_run_enable;
            rtc_time_pkg::ADDR_ALARM_MASK: read_mux[7:0] = state_reg.alarm_compare_mask;
            rtc_time_pkg::ADDR_PACKED_TIME_LOW: read_mux = packed_time_low;
            rtc_time_pkg::ADDR_PACKED_DATE: read_mux = packed_date;
            rtc_time_pkg::ADDR_PACKED_DAY_OF_YEAR: read_mux = packed_day_of_year;
            rtc_time_pkg::ADDR_SECONDS: read_mux[5:0] = state_reg.seconds_count;
            rtc_time_pkg::ADDR_MINUTES: read_mux[5:0] = state_reg.minutes_count;
            rtc_time_pkg::ADDR_HOURS: read_mux[4:0] = state_reg.hours_count;
            rtc_time_pkg::ADDR_DAY_OF_MONTH: read_mux[4:0] = state_reg.day_of_month_count;
            rtc_time_pkg::ADDR_WEEKDAY: read_mux[2:0] = state_reg.weekday_count;
            rtc_time_pkg::ADDR_DAY_OF_YEAR: read_mux[8:0] = state_reg.day_of_year_count;
            rtc_time_pkg::ADDR_MONTH: read_mux[3:0] = state_reg.month_count;
            rtc_time_pkg::ADDR_YEAR: read_mux[11:0] = state_reg.year_count;
            default: read_mux = '0;
        endcase
    end

    assign field_equal[rtc_time_pkg::MASK_SECONDS_COMPARE] = (state_reg.seconds_count == alarm_seconds);
    assign field_equal[rtc_time_pkg::MASK_MINUTES_COMPARE] = (state_reg.minutes_count == alarm_minutes);
    assign field_equal[rtc_time_pkg::MASK_HOURS_COMPARE] = (state_reg.hours_count == alarm_hours);
    assign field_equal[rtc_time_pkg::MASK_DAY_OF_MONTH_COMPARE] = (state_reg.day_of_month_count == alarm_day_of_month);
    assign field_equal[rtc_time_pkg::MASK_WEEKDAY_COMPARE] = (state_reg.weekday_count == alarm_weekday);
    assign field_equal[rtc_time_pkg::MASK_DAY_OF_YEAR_COMPARE] = (state_reg.day_of_year_count == alarm_day_of_year);
    assign field_equal[rtc_time_pkg::MASK_MONTH_COMPARE] = (state_reg.month_count == alarm_month);
    assign field_equal[rtc_time_pkg::MASK_YEAR_COMPARE] = (state_reg.year_count == alarm_year);

    // A set mask bit forces its field to count as matching.
    assign match_now = &(state_reg.alarm_compare_mask | field_equal);

    always_comb begin
        state_next = state_reg;
        state_next.match_prev = match_now;
        // Edge only, and never with every field masked.
        state_next.alarm_pulse = match_now & ~state_reg.match_prev & ~(&state_reg.alarm_compare_mask);

        if (tick_run) begin
            state_next.seconds_count = sec_wrap ? 6'h00 : state_reg.seconds_count + 6'h01;
        end
        if (sec_wrap) begin
            state_next.minutes_count = min_wrap ? 6'h00 : state_reg.minutes_count + 6'h01;
        end
        if (min_wrap) begin
            state_next.hours_count = hour_wrap ? 5'h00 : state_reg.hours_count + 5'h01;
        end
        if (hour_wrap) begin
            state_next.day_of_month_count = dom_wrap ? rtc_time_pkg::DOM_FIRST
                                                     : state_reg.day_of_month_count + 5'h01;
            state_next.weekday_count = (state_reg.weekday_count >= rtc_time_pkg::DOW_LAST) ? 3'h0
                                                     : state_reg.weekday_count + 3'h1;
            state_next.day_of_year_count = doy_wrap ? rtc_time_pkg::DOY_FIRST
                                                    : state_reg.day_of_year_count + 9'h001;
        end
        if (dom_wrap) begin
            state_next.month_count = month_wrap ? rtc_time_pkg::MONTH_FIRST : state_reg.month_count + 4'h1;
        end
        if (year_step) begin
            // Twelve bits wrap from 4095 to 0 on their own.
            state_next.year_count = state_reg.year_count + 12'h001;
        end

        // A software write to a counter wins over a carry arriving in the same cycle.
        if (wr_sec) state_next.seconds_count = pwdata[5:0];
        if (wr_min) state_next.minutes_count = pwdata[5:0];
        if (wr_hour) state_next.hours_count = pwdata[4:0];
        if (wr_dom) state_next.day_of_month_count = pwdata[4:0];
        if (wr_dow) state_next.weekday_count = pwdata[2:0];
        if (wr_doy) state_next.day_of_year_count = pwdata[8:0];
        if (wr_month) state_next.month_count = pwdata[3:0];
        if (wr_year) state_next.year_count = pwdata[11:0];
        if (wr & (paddr == rtc_time_pkg::ADDR_ALARM_MASK)) begin
            state_next.alarm_compare_mask = pwdata[7:0];
        end
        if (wr & (paddr == rtc_time_pkg::ADDR_RUN_CONTROL)) begin
            state_next.counter_run_enable = pwdata[rtc_time_pkg::RUN_ENABLE_BIT];
        end

        // Read data is captured in the setup cycle and stands through the access cycle.
        if (setup & ~pwrite) begin
            state_next.read_data = read_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.seconds_count <= rtc_time_pkg::RST_SECONDS;
            state_reg.minutes_count <= rtc_time_pkg::RST_MINUTES;
            state_reg.hours_count <= rtc_time_pkg::RST_HOURS;
            state_reg.day_of_month_count <= rtc_time_pkg::RST_DAY_OF_MONTH;
            state_reg.weekday_count <= rtc_time_pkg::RST_WEEKDAY;
            state_reg.day_of_year_count <= rtc_time_pkg::RST_DAY_OF_YEAR;
            state_reg.month_count <= rtc_time_pkg::RST_MONTH;
            state_reg.year_count <= rtc_time_pkg::RST_YEAR;
            state_reg.alarm_compare_mask <= rtc_time_pkg::RST_ALARM_MASK;
            state_reg.counter_run_enable <= rtc_time_pkg::RST_RUN_ENABLE;
            state_reg.read_data <= 32'h0000_0000;
            state_reg.match_prev <= 1'b0;
            state_reg.alarm_pulse <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_sec_wrap: assert property (sec_wrap && !wr_sec |=> state_reg.seconds_count == 6'h00)
        else $error("seconds did not wrap to zero");
    a_min_step: assert property (sec_wrap && !min_wrap && !wr_min |=>
        state_reg.minutes_count == $past(state_reg.minutes_count) + 6'h01)
        else $error("minutes did not advance on seconds rollover");
    a_hour_wrap: assert property (hour_wrap && !wr_hour |=> state_reg.hours_count == 5'h00)
        else $error("hours did not wrap after 23");
    a_dom_wrap: assert property (dom_wrap && !wr_dom |=> state_reg.day_of_month_count == 5'h01)
        else $error("day of month did not return to 1");
    a_dow_cycle: assert property (hour_wrap && state_reg.weekday_count == 3'h6 && !wr_dow |=>
        state_reg.weekday_count == 3'h0)
        else $error("weekday did not wrap after 6");
    a_doy_leap: assert property (hour_wrap && leap_year && !wr_doy &&
        state_reg.day_of_year_count == 9'h16d |=> state_reg.day_of_year_count == 9'h16e)
        else $error("day of year did not reach 366 in a leap year");
    a_month_wrap: assert property (month_wrap && !wr_month |=> state_reg.month_count == 4'h1)
        else $error("month did not return to 1");
    a_year_step: assert property (year_step && !wr_year |=>
        state_reg.year_count == $past(state_reg.year_count) + 12'h001)
        else $error("year did not advance on rollover");
    a_leap_feb: assert property (state_reg.month_count == 4'h2 && state_reg.year_count[1:0] == 2'b00 |->
        dom_last == 5'h1d)
        else $error("february length wrong in leap year");
    a_hold_stopped: assert property (!state_reg.counter_run_enable && !wr_any_counter |=>
        $stable(state_reg.seconds_count) && $stable(state_reg.year_count))
        else $error("counters moved while stopped");
    a_counter_write: assert property (wr_sec |=> state_reg.seconds_count == $past(pwdata[5:0]))
        else $error("seconds write not stored");
    a_view_readonly: assert property (wr && addr_view |-> pslverr ##1 $stable(state_reg.alarm_compare_mask))
        else $error("write to packed view not refused");
    a_view_time: assert property (setup && !pwrite && paddr == rtc_time_pkg::ADDR_PACKED_TIME_LOW |=>
        prdata[13:8] == $past(state_reg.minutes_count) && prdata[31:27] == 5'h00)
        else $error("packed time view misplaced");
    a_view_date: assert property (setup && !pwrite && paddr == rtc_time_pkg::ADDR_PACKED_DATE |=>
        prdata[27:16] == $past(state_reg.year_count) && prdata[11:8] == $past(state_reg.month_count))
        else $error("packed date view misplaced");
    a_view_doy: assert property (setup && !pwrite && paddr == rtc_time_pkg::ADDR_PACKED_DAY_OF_YEAR |=>
        prdata[31:12] == 20'h0_0000)
        else $error("day of year view upper bits not zero");
    a_alarm_edge: assert property (alarm_event |-> $past(match_now) && !$past(state_reg.match_prev))
        else $error("alarm without mismatch to match edge");
    a_alarm_off: assert property (&state_reg.alarm_compare_mask |=> !alarm_event)
        else $error("alarm fired with all fields masked");
    a_year_masked: assert property (state_reg.alarm_compare_mask[7:5] == 3'b111 &&
        (&field_equal[4:0]) |-> match_now)
        else $error("masked upper fields still compared");
    a_low_masked: assert property (state_reg.alarm_compare_mask[4:0] == 5'h1f &&
        (&field_equal[7:5]) |-> match_now)
        else $error("masked lower fields still compared");

    // Step checks skip cycles in which software overwrites the counter, since the write wins.
    a_sec_step: assert property (tick_run && !sec_wrap && !wr_sec |=>
        state_reg.seconds_count == $past(state_reg.seconds_count) + 6'h01)
        else $error("seconds did not advance on tick");
    a_min_wrap: assert property (min_wrap && !wr_min |=> state_reg.minutes_count == 6'h00)
        else $error("minutes did not wrap to zero");
    a_hour_step: assert property (min_wrap && !hour_wrap && !wr_hour |=>
        state_reg.hours_count == $past(state_reg.hours_count) + 5'h01)
        else $error("hours did not advance");
    a_dom_step: assert property (hour_wrap && !dom_wrap && !wr_dom |=>
        state_reg.day_of_month_count == $past(state_reg.day_of_month_count) + 5'h01)
        else $error("day of month did not advance");
    a_short_month: assert property (state_reg.month_count == 4'h4 |-> dom_last == 5'h1e)
        else $error("april length wrong");
    a_feb_normal: assert property (state_reg.month_count == 4'h2 && !leap_year |->
        dom_last == 5'h1c)
        else $error("february length wrong in common year");
    a_dow_step: assert property (hour_wrap && state_reg.weekday_count < 3'h6 && !wr_dow |=>
        state_reg.weekday_count == $past(state_reg.weekday_count) + 3'h1)
        else $error("weekday did not advance");
    a_doy_wrap: assert property (doy_wrap && !wr_doy |=> state_reg.day_of_year_count == 9'h001)
        else $error("day of year did not return to 1");
    a_month_step: assert property (dom_wrap && !month_wrap && !wr_month |=>
        state_reg.month_count == $past(state_reg.month_count) + 4'h1)
        else $error("month did not advance");
    a_view_pad: assert property (setup && !pwrite && paddr == rtc_time_pkg::ADDR_PACKED_TIME_LOW |=>
        prdata[7:6] == 2'b00 && prdata[15:14] == 2'b00 && prdata[23:21] == 3'b000)
        else $error("packed time view gaps not zero");
    a_run_gate: assert property (!state_reg.counter_run_enable |-> !tick_run)
        else $error("tick taken while stopped");

    c_sec_roll: cover property (sec_wrap);
    c_doy_roll: cover property (doy_wrap);
    c_year_roll: cover property (year_step);
    c_alarm: cover property (alarm_event);
    c_leap_feb_end: cover property (dom_wrap && leap_year && state_reg.month_count == 4'h2);

endmodule

/* rtc_time_counter_chain_test.sv */
`timescale 1ns/1ps
module rtc_time_counter_chain_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic alarm_event;
    logic one_second_tick = 1'b0;
    logic [5:0] alarm_seconds = 6'h05;
    logic [3:0] alarm_month = 4'h1;
    logic [11:0] alarm_year = 12'h0ff;
    logic [31:0] r;
    logic e;
    int miscompares = 0;
    int checks_done = 0;
    int alarms = 0;
    int base;

    rtc_time_counter_chain u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .one_second_tick(one_second_tick), .alarm_seconds(alarm_seconds), .alarm_minutes(6'h00), .alarm_hours(5'h00),
        .alarm_day_of_month(5'h01), .alarm_weekday(3'h0), .alarm_day_of_year(9'h001), .alarm_month(alarm_month),
        .alarm_year(alarm_year), .alarm_event(alarm_event));

    initial begin
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (alarm_event === 1'b1) alarms <= alarms + 1;
    end

    task print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Each transfer starts one edge after the last, so psel never gets two assignments in one step.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [31:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, exp);
        chk({31'h0000_0000, e}, {31'h0000_0000, experr});
    endtask

    task tick();
        @(posedge pclk);
        one_second_tick <= 1'b1;
        @(posedge pclk);
        one_second_tick <= 1'b0;
    endtask

    // Presets the last second of a day, then lets one tick carry through the chain.
    task roll(input logic [31:0] y, input logic [31:0] m, input logic [31:0] d, input logic [31:0] exp);
        wr(rtc_time_pkg::ADDR_YEAR, y);
        wr(rtc_time_pkg::ADDR_MONTH, m);
        wr(rtc_time_pkg::ADDR_DAY_OF_MONTH, d);
        wr(rtc_time_pkg::ADDR_SECONDS, 32'h0000_003b);
        wr(rtc_time_pkg::ADDR_MINUTES, 32'h0000_003b);
        wr(rtc_time_pkg::ADDR_HOURS, 32'h0000_0017);
        tick();
        rd(rtc_time_pkg::ADDR_PACKED_DATE, exp, 1'b0);
    endtask

    task test_reset_alarm();
        rd(rtc_time_pkg::ADDR_PACKED_TIME_LOW, 32'h0000_0000, 1'b0);
        rd(rtc_time_pkg::ADDR_PACKED_DATE, 32'h0000_0101, 1'b0);
        rd(rtc_time_pkg::ADDR_PACKED_DAY_OF_YEAR, 32'h0000_0001, 1'b0);
        base = alarms;
        wr(rtc_time_pkg::ADDR_ALARM_MASK, 32'h0000_007e);
        wr(rtc_time_pkg::ADDR_SECONDS, 32'h0000_0005);
        repeat (3) @(posedge pclk);
        chk(32'(alarms - base), 32'h0000_0000);
        alarm_month <= 4'h5;
        wr(rtc_time_pkg::ADDR_ALARM_MASK, 32'h0000_00fe);
        repeat (3) @(posedge pclk);
        chk(32'(alarms - base), 32'h0000_0001);
        wr(rtc_time_pkg::ADDR_SECONDS, 32'h0000_0000);
        wr(rtc_time_pkg::ADDR_ALARM_MASK, 32'h0000_00ff);
        wr(rtc_time_pkg::ADDR_SECONDS, 32'h0000_0005);
        repeat (3) @(posedge pclk);
        chk(32'(alarms - base), 32'h0000_0001);
        $display("Reset and alarm test done");
    endtask

    task test_chain();
        wr(rtc_time_pkg::ADDR_WEEKDAY, 32'h0000_0006);
        wr(rtc_time_pkg::ADDR_DAY_OF_YEAR, 32'h0000_016d);
        wr(rtc_time_pkg::ADDR_RUN_CONTROL, 32'h0000_0001);
        roll(32'h0000_0003, 32'h0000_000c, 32'h0000_001f, 32'h0004_0101);
        rd(rtc_time_pkg::ADDR_PACKED_TIME_LOW, 32'h0000_0000, 1'b0);
        rd(rtc_time_pkg::ADDR_PACKED_DAY_OF_YEAR, 32'h0000_0001, 1'b0);
        roll(32'h0000_0004, 32'h0000_0002, 32'h0000_001c, 32'h0004_021d);
        roll(32'h0000_0004, 32'h0000_0002, 32'h0000_001d, 32'h0004_0301);
        roll(32'h0000_0005, 32'h0000_0002, 32'h0000_001c, 32'h0005_0301);
        roll(32'h0000_0005, 32'h0000_0004, 32'h0000_001e, 32'h0005_0501);
        tick();
        rd(rtc_time_pkg::ADDR_SECONDS, 32'h0000_0001, 1'b0);
        wr(rtc_time_pkg::ADDR_RUN_CONTROL, 32'h0000_0000);
        tick();
        rd(rtc_time_pkg::ADDR_SECONDS, 32'h0000_0001, 1'b0);
        $display("Counter chain test done");
    endtask

    task test_refusals();
        wr(rtc_time_pkg::ADDR_PACKED_TIME_LOW, 32'h0000_0007);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        rd(rtc_time_pkg::ADDR_PACKED_TIME_LOW, 32'h0400_0001, 1'b0);
        rd(32'he002_4040, 32'h0000_0000, 1'b1);
        $display("Refusal test done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_alarm();
        test_chain();
        test_refusals();
        print_verdict();
    end
endmodule
